//--- src/pci_reset_and_clock_run.sv
// Purpose: Bus reset, global reset and clock-run handling on the bus side.
// Assumes: clk_in is the bus clock; all bus inputs synchronous to it.
// Notes: One output enable gates every bus output buffer of the device.
`timescale 1ns/1ps
`include "pci_rst_cfg.svh"

module pci_reset_and_clock_run (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic bus_reset_n_in,
  input wire logic suspend_in,
  input wire logic clk_run_in,
  output logic clk_run_out,
  output logic clk_run_oe_out,
  input wire logic cfg_write_in,
  input wire logic [31:0] cfg_data_in,
  input wire logic clock_req_in,
  input wire logic wake_event_in,
  input wire logic wake_enable_wr_in,
  input wire logic wake_enable_in,
  input wire logic wake_clear_in,
  output logic hold_clock_out,
  output logic wake_status_out,
  output logic wake_enable_out,
  output logic out_en_out,
  output logic active_out
);

  logic ctx_rst_b;
  logic core_rst_b;
  logic core_rst_src_b;
  logic need_clock;
  logic cfg_ok;
  pci_rst_pkg::core_t core;
  pci_rst_pkg::core_t next_core;
  pci_rst_pkg::ctx_t ctx;
  pci_rst_pkg::ctx_t next_ctx;

  reset_release_sync u_ctx_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .rst_sync_b_out(ctx_rst_b)
  );

  // suspend shields state
  // Suspend must be steady around bus reset edges or the core may glitch into reset
  assign core_rst_src_b = rst_b_in & (bus_reset_n_in | suspend_in);

  reset_release_sync u_core_sync (
    .clk_in(clk_in),
    .rst_b_in(core_rst_src_b),
    .rst_sync_b_out(core_rst_b)
  );

  // outputs float
  // Raw pins gate the buffers so they float before any clock edge
  assign out_en_out = rst_b_in & bus_reset_n_in & core_rst_b;
  assign active_out = core_rst_b;

  // No config access while the bus is in reset, even under suspend
  assign cfg_ok = cfg_write_in & bus_reset_n_in;
  assign need_clock = core.hold_clock | clock_req_in;

  always_comb begin
    next_core = core;
    if (cfg_ok) begin
      next_core.hold_clock = cfg_data_in[`SYS_CTRL_HOLD_CLOCK_BIT];
    end
    unique case (core.state)
      pci_rst_pkg::CR_IDLE: begin
        if (clk_run_in && need_clock && bus_reset_n_in) begin
          next_core.state = pci_rst_pkg::CR_DRIVE;
          next_core.cnt = `CR_CNT_RESET;
        end
      end
      pci_rst_pkg::CR_DRIVE: begin
        next_core.cnt = core.cnt + 2'h1;
        if (core.cnt == `CR_DRIVE_LAST) begin
          next_core.state = pci_rst_pkg::CR_WAIT;
        end
      end
      pci_rst_pkg::CR_WAIT: begin
        // Wait for the host to restore the clock before asking again
        if (!clk_run_in) begin
          next_core.state = pci_rst_pkg::CR_IDLE;
        end
      end
      default: begin
        next_core.state = pci_rst_pkg::CR_IDLE;
        next_core.cnt = `CR_CNT_RESET;
      end
    endcase
  end

  always_comb begin
    next_ctx = ctx;
    if (wake_enable_wr_in) begin
      next_ctx.wake_enable = wake_enable_in;
    end
    // Event wins over a clear in the same cycle
    if (wake_clear_in) begin
      next_ctx.wake_status = 1'b0;
    end
    if (wake_event_in) begin
      next_ctx.wake_status = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge core_rst_b) begin
    if (!core_rst_b) begin
      core <= {pci_rst_pkg::CR_IDLE, `CR_CNT_RESET, `HOLD_CLOCK_RESET};
    end else begin
      core <= next_core;
    end
  end

  always_ff @(posedge clk_in or negedge ctx_rst_b) begin
    if (!ctx_rst_b) begin
      ctx <= {`WAKE_STATUS_RESET, `WAKE_ENABLE_RESET};
    end else begin
      ctx <= next_ctx;
    end
  end

  assign clk_run_out = 1'b0;
  assign clk_run_oe_out = out_en_out & (core.state == pci_rst_pkg::CR_DRIVE);
  assign hold_clock_out = core.hold_clock;
  assign wake_status_out = ctx.wake_status;
  assign wake_enable_out = ctx.wake_enable;

  sequence s_cr_request;
    core.state == pci_rst_pkg::CR_IDLE && clk_run_in && need_clock && bus_reset_n_in;
  endsequence

  sequence s_cr_pulse;
    (clk_run_oe_out && !clk_run_out) [*2] ##1 !clk_run_oe_out;
  endsequence

  a_cr_pulse_two: assert property (
    @(posedge clk_in) disable iff (!core_rst_b || !bus_reset_n_in || !rst_b_in)
    s_cr_request |=> s_cr_pulse)
    else $error("clock-run pulse not two cycles");

  a_cr_quiet_idle: assert property (
    @(posedge clk_in) disable iff (!core_rst_b)
    core.state == pci_rst_pkg::CR_IDLE && !need_clock |=> !clk_run_oe_out)
    else $error("clock-run driven without need");

  a_hold_bit_write: assert property (
    @(posedge clk_in) disable iff (!core_rst_b)
    cfg_ok |=> hold_clock_out == $past(cfg_data_in[`SYS_CTRL_HOLD_CLOCK_BIT]))
    else $error("hold-clock bit not written");

  a_oe_bus_reset: assert property (
    @(posedge clk_in)
    !bus_reset_n_in |-> !out_en_out && !clk_run_oe_out)
    else $error("outputs driven in bus reset");

  a_release_default: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $rose(core_rst_b) |-> !hold_clock_out && core.state == pci_rst_pkg::CR_IDLE)
    else $error("not default after bus reset");

  a_suspend_keeps: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    core_rst_b && !bus_reset_n_in && suspend_in && $stable(suspend_in)
      |=> hold_clock_out == $past(hold_clock_out) && active_out)
    else $error("suspend lost state");

  a_global_clears: assert property (
    @(posedge clk_in)
    !rst_b_in |-> !out_en_out && !wake_status_out && !wake_enable_out && !active_out)
    else $error("global reset left state");

  a_wake_kept: assert property (
    @(posedge clk_in) disable iff (!ctx_rst_b)
    wake_status_out && !wake_clear_in |=> wake_status_out)
    else $error("wake context lost");

  a_sync_release: assert property (
    @(posedge clk_in) disable iff (!rst_b_in || !ctx_rst_b)
    $rose(bus_reset_n_in) && !suspend_in && !active_out
      ##1 bus_reset_n_in [*2] |-> ##0 active_out && $past(active_out, 2) == 1'b0)
    else $error("bus reset release not two cycles");

  a_tied_low_quiet: assert property (
    @(posedge clk_in) disable iff (!core_rst_b)
    core.state == pci_rst_pkg::CR_IDLE && !clk_run_in |=> !clk_run_oe_out)
    else $error("clock-run driven while line held low");

  a_cfg_refused: assert property (
    @(posedge clk_in) disable iff (!core_rst_b)
    cfg_write_in && !bus_reset_n_in |=> hold_clock_out == $past(hold_clock_out))
    else $error("config write taken during bus reset");

  a_bus_rst_wake: assert property (
    @(posedge clk_in) disable iff (!ctx_rst_b)
    !bus_reset_n_in && !wake_event_in && !wake_clear_in && !wake_enable_wr_in
      |=> $stable(wake_status_out) && $stable(wake_enable_out))
    else $error("bus reset touched wake context");

endmodule : pci_reset_and_clock_run

//--- src/pci_rst_cfg.svh
// Purpose: Constants for the bus reset and clock-run block.
// Assumes: Included by bare name from the two modules; the package does not include it.
// Notes: Definitions only.
`ifndef PCI_RST_CFG_SVH
`define PCI_RST_CFG_SVH

// System control register image
`define SYS_CTRL_HOLD_CLOCK_BIT 1
`define HOLD_CLOCK_RESET 1'h0

// Cycles the device pulls the clock-run line low when it asks to keep the clock
`define CR_DRIVE_CYCLES 2'h2
`define CR_DRIVE_LAST 2'h1
`define CR_CNT_RESET 2'h0

// Wake context reset values
`define WAKE_STATUS_RESET 1'h0
`define WAKE_ENABLE_RESET 1'h0

// Two-flop release synchroniser reset value
`define SYNC_RESET 1'h0

`endif

//--- src/pci_rst_pkg.sv
// Purpose: Types for the bus reset and clock-run block.
// Assumes: Constants come from pci_rst_cfg.svh.
// Notes: No timescale, package only.
package pci_rst_pkg;

  typedef enum logic [2:0] {
    CR_IDLE  = 3'b001,
    CR_DRIVE = 3'b010,
    CR_WAIT  = 3'b100
  } cr_state_t;

  // Cleared by bus reset unless suspend protects it
  typedef struct packed {
    cr_state_t state;
    logic [1:0] cnt;
    logic hold_clock;
  } core_t;

  // Cleared by global reset only
  typedef struct packed {
    logic wake_status;
    logic wake_enable;
  } ctx_t;

  typedef struct packed {
    logic meta;
    logic held;
  } sync_t;

endpackage : pci_rst_pkg

//--- src/reset_release_sync.sv
// Purpose: Asynchronous assert, synchronous release of an active-low reset.
// Assumes: clk_in is the bus clock.
// Notes: First flop feeds only the second.
`timescale 1ns/1ps
`include "pci_rst_cfg.svh"

module reset_release_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  output logic rst_sync_b_out
);

  pci_rst_pkg::sync_t sync;
  pci_rst_pkg::sync_t next_sync;

  always_comb begin
    next_sync.meta = 1'b1;
    next_sync.held = sync.meta;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync <= {`SYNC_RESET, `SYNC_RESET};
    end else begin
      sync <= next_sync;
    end
  end

  assign rst_sync_b_out = sync.held;

endmodule : reset_release_sync

//--- tb/cr_host.sv
// Purpose: Host end of the clock-run wire.
// Assumes: Wire is pulled up while nobody drives it.
// Notes: Releases on a stop request, drives low again once it sees low.
`timescale 1ns/1ps
module cr_host (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic stop_req_in,
  input wire logic dev_oe_in,
  input wire logic dev_val_in,
  output logic line_out
);
  logic rel;
  assign line_out = !rel ? 1'h0 : (dev_oe_in ? dev_val_in : 1'h1);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rel <= 1'h0;
    end else if (stop_req_in) begin
      rel <= 1'h1;
    end else if (!line_out) begin
      rel <= 1'h0;
    end
  end
endmodule : cr_host

//--- tb/pci_reset_and_clock_run_tb.sv
// Purpose: Self-checking bench for bus reset, global reset and clock-run.
// Assumes: Inputs change on the falling edge only.
// Notes: Host model owns the clock-run wire.
`timescale 1ns/1ps
module pci_reset_and_clock_run_tb;
  logic clk_in = 1'h0;
  logic rst_b_in = 1'h1;
  logic bus_reset_n_in = 1'h1;
  logic suspend_in = 1'h0;
  logic stop_req = 1'h0;
  logic cfg_write_in = 1'h0;
  logic [31:0] cfg_data_in = 32'h0;
  logic clock_req_in = 1'h0;
  logic wake_event_in = 1'h0;
  logic wake_enable_wr_in = 1'h0;
  logic wake_enable_in = 1'h0;
  logic wake_clear_in = 1'h0;
  logic clk_run_in, clk_run_out, clk_run_oe_out, hold_clock_out, wake_status_out;
  logic wake_enable_out, out_en_out, active_out;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  always #25 clk_in = ~clk_in;
  pci_reset_and_clock_run pci_reset_and_clock_run_inst (.clk_in, .rst_b_in, .bus_reset_n_in,
    .suspend_in, .clk_run_in, .clk_run_out, .clk_run_oe_out, .cfg_write_in, .cfg_data_in,
    .clock_req_in, .wake_event_in, .wake_enable_wr_in, .wake_enable_in, .wake_clear_in,
    .hold_clock_out, .wake_status_out, .wake_enable_out, .out_en_out, .active_out);
  cr_host cr_host_inst (.clk_in, .rst_b_in, .stop_req_in(stop_req), .dev_oe_in(clk_run_oe_out),
    .dev_val_in(clk_run_out), .line_out(clk_run_in));
  task automatic chk(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(negedge clk_in);
  endtask : step
  task automatic wr_hold(input logic v);
    cfg_write_in = 1'h1;
    cfg_data_in = {30'h0, v, 1'h0};
    step(1);
    cfg_write_in = 1'h0;
  endtask : wr_hold
  // Counts cycles the device pulls the wire over a window
  task automatic drive_count(output int n);
    n = 0;
    repeat (8) begin
      step(1);
      if (clk_run_oe_out === 1'h1) n++;
    end
  endtask : drive_count
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      final_report();
    end
  end
  task automatic t_clkrun;
    int n;
    stop_req = 1'h1;
    step(1);
    stop_req = 1'h0;
    drive_count(n);
    chk("no need no drive", 1'h1, n == 0);
    chk("wire released", 1'h1, clk_run_in);
    clock_req_in = 1'h1;
    drive_count(n);
    chk("keep drive", 1'h1, n == 2);
    chk("pull low value", 1'h0, clk_run_out);
    chk("wire low again", 1'h0, clk_run_in);
    // Line held low with need raised must not start a pulse
    drive_count(n);
    chk("tied low quiet", 1'h1, n == 0);
    clock_req_in = 1'h0;
    wr_hold(1'h1);
    chk("hold bit", 1'h1, hold_clock_out);
    stop_req = 1'h1;
    step(1);
    stop_req = 1'h0;
    drive_count(n);
    chk("hold drive", 1'h1, n == 2);
  endtask : t_clkrun
  task automatic t_bus_reset;
    wake_event_in = 1'h1;
    step(1);
    wake_event_in = 1'h0;
    chk("wake set", 1'h1, wake_status_out);
    bus_reset_n_in = 1'h0;
    cfg_write_in = 1'h1;
    cfg_data_in = 32'h2;
    #1;
    chk("float", 1'h0, out_en_out);
    step(2);
    cfg_write_in = 1'h0;
    chk("inactive", 1'h0, active_out);
    chk("hold cleared", 1'h0, hold_clock_out);
    bus_reset_n_in = 1'h1;
    step(2);
    chk("active again", 1'h1, active_out);
    chk("default hold", 1'h0, hold_clock_out);
    chk("wake kept", 1'h1, wake_status_out);
  endtask : t_bus_reset
  task automatic t_suspend;
    wr_hold(1'h1);
    suspend_in = 1'h1;
    step(1);
    bus_reset_n_in = 1'h0;
    // Write of zero during bus reset must be refused
    cfg_write_in = 1'h1;
    cfg_data_in = 32'h0;
    #1;
    chk("suspend float", 1'h0, out_en_out);
    step(2);
    cfg_write_in = 1'h0;
    chk("suspend active", 1'h1, active_out);
    chk("suspend hold", 1'h1, hold_clock_out);
    bus_reset_n_in = 1'h1;
    step(2);
    suspend_in = 1'h0;
    chk("drive again", 1'h1, out_en_out);
  endtask : t_suspend
  task automatic t_global;
    wake_enable_in = 1'h1;
    wake_enable_wr_in = 1'h1;
    wake_clear_in = 1'h1;
    wake_event_in = 1'h1;
    step(1);
    wake_enable_wr_in = 1'h0;
    wake_event_in = 1'h0;
    chk("wake enable", 1'h1, wake_enable_out);
    chk("event beats clear", 1'h1, wake_status_out);
    step(1);
    wake_clear_in = 1'h0;
    wake_event_in = 1'h1;
    chk("wake clear", 1'h0, wake_status_out);
    step(1);
    wake_event_in = 1'h0;
    chk("wake set again", 1'h1, wake_status_out);
    rst_b_in = 1'h0;
    #1;
    chk("global float", 1'h0, out_en_out);
    chk("wake status clr", 1'h0, wake_status_out);
    chk("wake enable clr", 1'h0, wake_enable_out);
    chk("global hold", 1'h0, hold_clock_out);
    step(1);
    rst_b_in = 1'h1;
    step(1);
    chk("sync one edge", 1'h0, active_out);
    step(1);
    chk("sync two edges", 1'h1, active_out);
  endtask : t_global
  initial begin
    // Nonblocking so every async reset sees the falling edge at time zero
    rst_b_in <= 1'h0;
    bus_reset_n_in <= 1'h0;
    step(6);
    chk("reset float", 1'h0, out_en_out);
    // Boot with both resets from one source, later tests pulse bus reset and then global reset
    rst_b_in = 1'h1;
    bus_reset_n_in = 1'h1;
    step(1);
    chk("boot one edge", 1'h0, active_out);
    step(1);
    chk("boot active", 1'h1, out_en_out);
    chk("hold default", 1'h0, hold_clock_out);
    t_clkrun();
    t_bus_reset();
    t_suspend();
    t_global();
    final_report();
  end
endmodule : pci_reset_and_clock_run_tb
